// [sfc_pkg.sv]
package sfc_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam logic [7:0] SFC_ADDR_CTL      = 8'h28;
  localparam int         SFC_BIT_FORCE_INT = 3;
  localparam int         SFC_BIT_ACT_HOLD  = 2;
  localparam int         SFC_MODE_MSB      = 1;
  localparam int         SFC_MODE_LSB      = 0;
  localparam logic [7:0] SFC_RSVD_MASK     = 8'hF0;

  localparam logic [1:0] SFC_MODE_NORMAL   = 2'h0;
  localparam logic [1:0] SFC_MODE_NOW      = 2'h1;
  localparam logic [1:0] SFC_MODE_DELAY    = 2'h2;
  localparam logic [1:0] SFC_MODE_EVENT    = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SFC_CLK_HZ       = 25000000;
  localparam int SFC_RESUME_MS    = 1000;
  localparam int SFC_RESUME_CYC   = SFC_CLK_HZ / 1000 * SFC_RESUME_MS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    SFC_IDLE   = 4'h1,
    SFC_PDOWN  = 4'h2,
    SFC_WAIT   = 4'h4,
    SFC_RESUME = 4'h8
  } sfc_state_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfc_wr_t;

endpackage : sfc_pkg

// [sfc_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Force bit set drives the interrupt output low unconditionally.
// - Force bit clear lets only flagged interrupt sources drive the output.
// - Active-hold flag set masks the sleep pin; clear passes it through.
// - Bus writes may clear the active-hold flag, never set it.
// - Entering power-up sequence one sets the active-hold flag.
// - Button off, mode 00: activation pin controls sequencing normally.
// - Button off, mode 01: power down, then pin control at once.
// - Button off, mode 10: power down, pin control after one second.
// - Button off, mode 11: power down, resume on pin low or alarm.
// - Button enable bit selects which meaning the mode field has.
// - Button on, mode 00: button input controls sequencing normally.
// - Button on, mode 01: power down, then straight to sequence one.
// - Button on, mode 10: sequence one after one second or press.
// - Button on, mode 11: sequence one on alarm or earlier press.
// - Writes accepted only while the control group is unprotected.
// - Register contents load from non-volatile memory at power-on.
// - Enabled RTC wake alarm sets the active-hold flag.
module sfc_ctrl
  import sfc_pkg::*;
#(
  parameter int RESUME_CYC = SFC_RESUME_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire sfc_wr_t    bus_wr,
  input  wire logic [7:0] bus_addr,
  output logic [7:0]      bus_rdata,
  input  wire logic       ctl_protected,
  input  wire logic       nvm_load,
  input  wire logic [7:0] nvm_data,
  input  wire logic       irq_pending,
  output logic            interrupt_out_n,
  input  wire logic       button_altfunc_enable,
  input  wire logic       rtc_wake_en,
  input  wire logic       rtc_alarm,
  input  wire logic       seq1_enter,
  input  wire logic       activation_pin,
  input  wire logic       power_button_in_n,
  input  wire logic       sleep_pin_n,
  output logic            sleep_request,
  output logic            power_down_req,
  output logic            resume_pulse,
  output logic            act_override,
  output logic            button_control
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] pin_s2_r;
  logic       act_s;
  logic       btn_pressed;
  logic       sleep_s_n;

  // Reset loads the idle-high level, so no false press follows reset.
  sfc_sync #(
    .WIDTH (3),
    .INIT  (3'h7)
  ) sfc_sync_inst (
    .clk (clk),
    .rst (rst),
    .d   ({activation_pin, power_button_in_n, sleep_pin_n}),
    .q   (pin_s2_r)
  );

  assign act_s       = pin_s2_r[2];
  assign btn_pressed = ~pin_s2_r[1];
  assign sleep_s_n   = pin_s2_r[0];

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic       force_int_r;
  logic       active_hold_flag_r;
  logic [1:0] forced_shutdown_mode_r;
  logic       wr_hit;
  logic       mode_done;
  logic       addr_hit;
  logic       hold_set;
  logic       hold_clear;

  assign addr_hit   = bus_wr.wr && (bus_wr.addr == SFC_ADDR_CTL);
  assign wr_hit     = addr_hit && !ctl_protected;
  assign hold_set   = seq1_enter || (rtc_wake_en && rtc_alarm);
  // Only a written zero clears the flag; a written one is ignored.
  assign hold_clear = wr_hit && !bus_wr.wdata[SFC_BIT_ACT_HOLD];

  // Writes to bits 7:4 are dropped and nothing stores them.
  always_ff @(posedge clk) begin
    if (rst) begin
      force_int_r <= 1'b0;
    end else if (nvm_load) begin
      force_int_r <= nvm_data[SFC_BIT_FORCE_INT];
    end else if (wr_hit) begin
      force_int_r <= bus_wr.wdata[SFC_BIT_FORCE_INT];
    end
  end

  // Hardware set beats a simultaneous bus clear, so a wake that lands
  // on the same cycle as a host clear is never lost.
  always_ff @(posedge clk) begin
    if (rst) begin
      active_hold_flag_r <= 1'b0;
    end else if (nvm_load) begin
      active_hold_flag_r <= nvm_data[SFC_BIT_ACT_HOLD];
    end else if (hold_set) begin
      active_hold_flag_r <= 1'b1;
    end else if (hold_clear) begin
      active_hold_flag_r <= 1'b0;
    end
  end

  // The mode field returns to normal once the forced cycle resumes,
  // so a single write requests a single shutdown cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      forced_shutdown_mode_r <= SFC_MODE_NORMAL;
    end else if (nvm_load) begin
      forced_shutdown_mode_r <= nvm_data[SFC_MODE_MSB:SFC_MODE_LSB];
    end else if (wr_hit) begin
      forced_shutdown_mode_r <= bus_wr.wdata[SFC_MODE_MSB:SFC_MODE_LSB];
    end else if (mode_done) begin
      forced_shutdown_mode_r <= SFC_MODE_NORMAL;
    end
  end

  // ****************************************************************
  // Read-back
  // ****************************************************************
  // The read path is a plain mux of the flops, so a read shows a write
  // on the cycle after the write is taken.
  always_comb begin
    bus_rdata = 8'h00;
    if (bus_addr == SFC_ADDR_CTL) begin
      bus_rdata = {4'h0, force_int_r, active_hold_flag_r,
                   forced_shutdown_mode_r} & ~SFC_RSVD_MASK;
    end
  end

  // ****************************************************************
  // Interrupt output and sleep gating
  // ****************************************************************
  logic irq_n_r;
  logic sleep_r;

  // Forcing low lets software prove the line is not shorted high.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_n_r <= 1'b1;
    end else if (force_int_r) begin
      irq_n_r <= 1'b0;
    end else begin
      irq_n_r <= ~irq_pending;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_r <= 1'b0;
    end else if (active_hold_flag_r) begin
      sleep_r <= 1'b0;
    end else begin
      sleep_r <= ~sleep_s_n;
    end
  end

  assign interrupt_out_n = irq_n_r;
  assign sleep_request   = sleep_r;

  // ****************************************************************
  // Forced shutdown sequencing
  // ****************************************************************
  sfc_state_t  state_r;
  sfc_state_t  state_nxt;
  logic [24:0] cnt_r;
  logic        timer_done;
  logic        early_exit;
  logic        resume_go;

  assign timer_done = (cnt_r >= 25'(RESUME_CYC - 1));
  assign mode_done  = (state_r == SFC_RESUME);

  // The enable bit picks pin-based or button-based wake sources; in
  // pin mode only the event mode lets the pin cut the wait short.
  always_comb begin
    if (button_altfunc_enable) begin
      early_exit = btn_pressed;
    end else begin
      early_exit = (forced_shutdown_mode_r == SFC_MODE_EVENT)
                   && !act_s;
    end
  end

  // A mode rewritten during the wait takes effect at once, so the wait
  // never hangs on a mode that has no wake source.
  always_comb begin
    resume_go = 1'b0;
    case (forced_shutdown_mode_r)
      SFC_MODE_NOW: begin
        resume_go = 1'b1;
      end
      SFC_MODE_DELAY: begin
        resume_go = timer_done || early_exit;
      end
      SFC_MODE_EVENT: begin
        resume_go = rtc_alarm || early_exit;
      end
      default: begin
        resume_go = 1'b0;
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SFC_IDLE: begin
        if (forced_shutdown_mode_r != SFC_MODE_NORMAL) begin
          state_nxt = SFC_PDOWN;
        end
      end
      SFC_PDOWN: begin
        if (forced_shutdown_mode_r == SFC_MODE_NOW) begin
          state_nxt = SFC_RESUME;
        end else begin
          state_nxt = SFC_WAIT;
        end
      end
      SFC_WAIT: begin
        if (forced_shutdown_mode_r == SFC_MODE_NORMAL) begin
          state_nxt = SFC_IDLE;
        end else if (resume_go) begin
          state_nxt = SFC_RESUME;
        end
      end
      SFC_RESUME: state_nxt = SFC_IDLE;
      default:    state_nxt = SFC_IDLE;
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SFC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // One-second resume timer
  // ****************************************************************
  // The count stops at its end value, so timer_done stays true while
  // the wait lasts and the counter can never wrap round.
  always_ff @(posedge clk) begin
    if (rst || state_r != SFC_WAIT) begin
      cnt_r <= 25'h0000000;
    end else if (!timer_done) begin
      cnt_r <= cnt_r + 25'h0000001;
    end
  end

  // ****************************************************************
  // Sequencer requests
  // ****************************************************************
  logic pd_r;
  logic res_r;
  logic ovr_r;

  // Registered from the next state so each request lines up with the
  // state it describes, with no extra cycle of lag.
  always_ff @(posedge clk) begin
    if (rst) begin
      pd_r <= 1'b0;
    end else begin
      pd_r <= (state_nxt == SFC_PDOWN) || (state_nxt == SFC_WAIT);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      res_r <= 1'b0;
    end else begin
      res_r <= (state_nxt == SFC_RESUME);
    end
  end

  // In button mode resume behaves as if the activation pin were high.
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr_r <= 1'b0;
    end else begin
      ovr_r <= (state_nxt == SFC_RESUME) && button_altfunc_enable;
    end
  end

  assign power_down_req = pd_r;
  assign resume_pulse   = res_r;
  assign act_override   = ovr_r;
  assign button_control = button_altfunc_enable;

endmodule : sfc_ctrl

// ****************************************************************
// Two-flop pin synchroniser
// ****************************************************************
// Only the second stage leaves the module, so no logic can ever see a
// first stage that is still settling.
module sfc_sync
  import sfc_pkg::*;
#(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_r <= INIT;
      stage2_r <= INIT;
    end else begin
      stage1_r <= d;
      stage2_r <= stage1_r;
    end
  end

  assign q = stage2_r;

endmodule : sfc_sync

`default_nettype wire

// [sfc_host.sv]
`timescale 1ns/100ps
`default_nettype none
module sfc_host
  import sfc_pkg::*;
(
  input  wire logic clk,
  output var sfc_wr_t bus_wr
);
  initial bus_wr = '{wr: 1'b0, addr: 8'h00, wdata: 8'h00};
  // Released fields show the inverse so a stale sample cannot match.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    bus_wr = '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk) #1;
    bus_wr = '{wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
endmodule : sfc_host
`default_nettype wire

// [sfc_ctrl_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module sfc_ctrl_checker
  import sfc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire sfc_wr_t    bus_wr,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_rdata,
  input wire logic       ctl_protected,
  input wire logic       nvm_load,
  input wire logic       irq_pending,
  input wire logic       interrupt_out_n,
  input wire logic       rtc_wake_en,
  input wire logic       rtc_alarm,
  input wire logic       seq1_enter,
  input wire logic       sleep_request,
  input wire logic       power_down_req
);
  // The register is only visible while the read address points at it.
  wire logic sel = bus_addr == SFC_ADDR_CTL;
  wire logic hw  = seq1_enter | (rtc_wake_en & rtc_alarm) | nvm_load;
  wire logic wok = bus_wr.wr && bus_wr.addr == SFC_ADDR_CTL
                   && !ctl_protected && !nvm_load;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  force_irq_a: assert property (
    wok && bus_wr.wdata[3] |-> ##2 !interrupt_out_n)
    else $error("interrupt output not forced low");
  irq_follow_a: assert property (
    sel |=> interrupt_out_n == !($past(bus_rdata[3]) | $past(irq_pending)))
    else $error("interrupt output mismatch");
  hold_noset_a: assert property (
    sel && !bus_rdata[2] && !hw |=> !sel || !bus_rdata[2])
    else $error("hold flag set by bus");
  hold_seq1_a: assert property (
    seq1_enter && !nvm_load |=> !sel || bus_rdata[2])
    else $error("hold flag not set on power-up");
  rtc_hold_a: assert property (
    rtc_wake_en && rtc_alarm && !nvm_load |=> !sel || bus_rdata[2])
    else $error("hold flag not set on wake alarm");
  sleep_mask_a: assert property (
    sel && bus_rdata[2] |=> !sleep_request)
    else $error("sleep request while held");
  protect_hold_a: assert property (
    sel && ctl_protected && !hw && !power_down_req
    && bus_rdata[1:0] == SFC_MODE_NORMAL |=> !sel || $stable(bus_rdata))
    else $error("protected register changed");
  rsvd_zero_a: assert property (
    sel |-> (bus_rdata & SFC_RSVD_MASK) == 8'h00)
    else $error("reserved bits not zero");
  shdn_start_a: assert property (
    wok && bus_wr.wdata[1:0] != SFC_MODE_NORMAL && !power_down_req
    |-> ##2 power_down_req)
    else $error("forced shutdown not started");
endmodule : sfc_ctrl_checker
bind sfc_ctrl sfc_ctrl_checker sfc_ctrl_checker_inst (.*);
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t %h %h", $time, (a), (e)); end end
module tb_top
  import sfc_pkg::*;
;
  localparam int RC = 20;
  logic       clk, rst, ctl_protected, nvm_load, irq_pending;
  logic       button_altfunc_enable, rtc_wake_en, rtc_alarm, seq1_enter;
  logic       activation_pin, power_button_in_n, sleep_pin_n;
  logic       interrupt_out_n, sleep_request, power_down_req;
  logic       resume_pulse, act_override, button_control;
  logic [7:0] bus_addr, nvm_data, bus_rdata;
  sfc_wr_t    bus_wr;
  int         miscompares, n_checks, cyc;
  sfc_ctrl #(.RESUME_CYC(RC)) sfc_ctrl_inst (.*);
  sfc_host sfc_host_inst (.clk(clk), .bus_wr(bus_wr));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic print_verdict;
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic w(input logic [7:0] d);
    sfc_host_inst.wr(SFC_ADDR_CTL, d);
  endtask : w
  task automatic t_load;
    `CHK(bus_rdata, 8'h00)
    nvm_load = 1'b1;
    tick(1);
    nvm_load = 1'b0;
    `CHK(bus_rdata, 8'h04)
  endtask : t_load
  task automatic t_irq;
    w(8'h0C);
    tick(1);
    `CHK(interrupt_out_n, 1'b0)
    irq_pending = 1'b1;
    w(8'h04);
    tick(2);
    `CHK(interrupt_out_n, 1'b0)
    irq_pending = 1'b0;
    tick(2);
    `CHK(interrupt_out_n, 1'b1)
  endtask : t_irq
  task automatic t_hold;
    sleep_pin_n = 1'b0;
    tick(4);
    `CHK(sleep_request, 1'b0)
    w(8'h00);
    tick(2);
    `CHK(sleep_request, 1'b1)
    w(8'h04);
    `CHK(bus_rdata[2], 1'b0)
    seq1_enter = 1'b1;
    tick(1);
    seq1_enter = 1'b0;
    `CHK(bus_rdata[2], 1'b1)
    w(8'h00);
    {rtc_wake_en, rtc_alarm} = 2'h3;
    tick(1);
    {rtc_wake_en, rtc_alarm} = 2'h0;
    `CHK(bus_rdata[2], 1'b1)
    sleep_pin_n = 1'b1;
  endtask : t_hold
  task automatic t_protect;
    ctl_protected = 1'b1;
    w(8'h08);
    `CHK(bus_rdata, 8'h04)
    ctl_protected = 1'b0;
    w(8'hF4);
    `CHK(bus_rdata, 8'h04)
    bus_addr = 8'h29;
    tick(1);
    `CHK(bus_rdata, 8'h00)
    bus_addr = SFC_ADDR_CTL;
  endtask : t_protect
  task automatic t_normal(input logic en);
    button_altfunc_enable = en;
    w(8'h04);
    tick(8);
    `CHK(power_down_req, 1'b0)
    `CHK(button_control, en)
  endtask : t_normal
  // Early trigger is the button in button mode and the pin otherwise.
  task automatic t_shdn(input logic en, input logic [1:0] m,
                        input logic early);
    int n;
    int lo;
    n = 0;
    lo = (m == SFC_MODE_NOW) ? 0 : 6;
    if (m == SFC_MODE_DELAY && !(early && en)) lo = RC;
    button_altfunc_enable = en;
    w({6'h01, m});
    while (resume_pulse !== 1'b1 && n < 100) begin
      tick(1);
      n++;
      if (n == 1) `CHK(power_down_req, 1'b1)
      if (n == 6) begin
        rtc_alarm = (m == SFC_MODE_EVENT) && !early;
        power_button_in_n = !(early && en);
        activation_pin = !(early && !en);
      end
      if (n == 7) rtc_alarm = 1'b0;
    end
    `CHK({lo <= n, n < lo + 12}, 2'b11)
    `CHK(act_override, en)
    {power_button_in_n, activation_pin} = 2'h3;
    tick(4);
    `CHK(bus_rdata[1:0], SFC_MODE_NORMAL)
    `CHK(power_down_req, 1'b0)
  endtask : t_shdn
  initial begin
    {rst, ctl_protected, nvm_load, irq_pending} = 4'h8;
    {button_altfunc_enable, rtc_wake_en, rtc_alarm, seq1_enter} = 4'h0;
    {activation_pin, power_button_in_n, sleep_pin_n} = 3'h7;
    bus_addr = SFC_ADDR_CTL;
    nvm_data = 8'hA4;
    miscompares = 0;
    n_checks = 0;
    tick(3);
    rst = 1'b0;
    t_load();
    t_irq();
    t_hold();
    t_protect();
    for (int e = 0; e < 2; e++) begin
      t_normal(e[0]);
      for (int m = 1; m < 4; m++) t_shdn(e[0], m[1:0], 1'b0);
      t_shdn(e[0], SFC_MODE_DELAY, 1'b1);
      t_shdn(e[0], SFC_MODE_EVENT, 1'b1);
    end
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
